//--- rtl/rx_payload_signaling_regs.sv
// Contract
// - transmit enable bit clear turns off every transmit payload function; set turns all on
// - receive enable bit clear turns off every receive payload function; set turns all on
// - position select 1 in ESF/SLC-96 puts signaling in upper two nibble bits only
// - access status busy reads 1 during an indirect transfer, 0 otherwise
// - control bit 7 picks write (0) or read (1); bits 6:0 address
// - payload indirect addresses 01-18, 21-38 and 41-58 are accepted
// - signaling buffer indirect addresses 01-18 only are accepted
// - indirect write: load data first, then control with direction 0 starts it
// - indirect read: control with direction 1, result then appears in data register
// - snapshot in sync holds first frame signaling for the whole superframe
// - global trunk conditioning replaces all channels' ABCD; else per-channel enable
// - global substitution: per-channel, data trunk code, A-law or mu-law milliwatt
// - fix enable forces ABCD to the chosen level in SF, ESF, SLC-96
// - freeze holds stored ABCD at the previous valid value
// - de-bounce stores ABCD only after two equal codewords in a row
// - interrupt enable gates any set change flag onto the interrupt output
// - width select 0 in ESF/SLC-96 keeps only A and B
// - width select 1 keeps A, B, C and D
// - change flag per channel sets on change; writing 1 clears it
`timescale 1ns/10ps
`include "rx_payload_signaling_defines.svh"

module rx_payload_signaling_regs
  import sig_regs_pkg::*;
#(
  parameter int NUM_CHANNELS  = 24,
  parameter int ACCESS_CYCLES = `ACCESS_CYCLES
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic [7:0]    addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [7:0]    rdata,
  input  wire frame_format_t frame_format,
  input  wire logic          in_sync,
  input  wire logic          superframe_start,
  input  wire logic          sig_word_valid,
  input  wire logic [4:0]    sig_word_chan,
  input  wire logic [3:0]    sig_word_abcd,
  input  wire logic          payload_valid,
  input  wire logic [4:0]    payload_chan,
  input  wire logic [7:0]    payload_in,
  output logic               payload_out_valid,
  output logic      [7:0]    payload_out,
  output logic      [3:0]    rx_signaling_out_pin,
  output logic               tx_payload_functions_enable,
  output logic               tx_signaling_position_select,
  output logic               signaling_irq
);

  localparam int CH = NUM_CHANNELS;

  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 24) begin : g_bad_channels
    $error("NUM_CHANNELS must be 1..24");
  end

  // ----------------------------------------
  // direct registers
  // ----------------------------------------
  logic [7:0]  tx_ctrl_enable_reg;
  logic [7:0]  rx_config_reg;
  logic [7:0]  rx_ctrl_enable_reg;
  logic [7:0]  sigbuf_config_reg;
  logic [23:0] change_flag_reg;
  logic [7:0]  rdata_reg;
  logic        irq_reg;

  logic        wr_txe, wr_rxc, wr_rxe, wr_sbc;
  logic [23:0] change_clear;
  logic [23:0] change_set;

  assign wr_txe = wr && (addr == `OFS_TX_PAYLOAD_CTRL_ENABLE);
  assign wr_rxc = wr && (addr == `OFS_RX_PAYLOAD_CONFIG);
  assign wr_rxe = wr && (addr == `OFS_RX_PAYLOAD_CTRL_ENABLE);
  assign wr_sbc = wr && (addr == `OFS_RX_SIGNALING_BUFFER_CONFIG);

  // reserved bits are kept at zero so they read back as zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl_enable_reg <= `RST_ZERO_BYTE;
      rx_config_reg      <= `RST_RX_PAYLOAD_CONFIG;
      rx_ctrl_enable_reg <= `RST_ZERO_BYTE;
      sigbuf_config_reg  <= `RST_SIGNALING_CONFIG;
    end else begin
      if (wr_txe) tx_ctrl_enable_reg <= wdata & 8'h09;
      if (wr_rxc) rx_config_reg <= wdata & 8'hc7;
      if (wr_rxe) rx_ctrl_enable_reg <= wdata & 8'h0f;
      if (wr_sbc) sigbuf_config_reg <= wdata & 8'h0f;
    end
  end

  logic       rx_enable, fix_en, fix_level, pos_sel, snap_en, gtrk_en;
  logic       freeze, debounce, irq_en, width_sel;
  logic [2:0] global_substitution_select;

  assign rx_enable = rx_ctrl_enable_reg[`BIT_FUNCTIONS_ENABLE];
  assign fix_en    = rx_ctrl_enable_reg[`BIT_FIX_ENABLE];
  assign fix_level = rx_ctrl_enable_reg[`BIT_FIX_LEVEL];
  assign pos_sel   = rx_ctrl_enable_reg[`BIT_POSITION_SELECT];
  assign snap_en   = rx_config_reg[`BIT_SNAPSHOT_ENABLE];
  assign gtrk_en   = rx_config_reg[`BIT_GLOBAL_TRUNK];
  assign global_substitution_select    = rx_config_reg[2:0];
  assign freeze    = sigbuf_config_reg[`BIT_FREEZE];
  assign debounce  = sigbuf_config_reg[`BIT_DEBOUNCE];
  assign irq_en    = sigbuf_config_reg[`BIT_IRQ_ENABLE];
  assign width_sel = sigbuf_config_reg[`BIT_WIDTH_SELECT];

  // transmit path lives elsewhere; it gets the enable and position select
  assign tx_payload_functions_enable  = tx_ctrl_enable_reg[`BIT_FUNCTIONS_ENABLE];
  assign tx_signaling_position_select = tx_ctrl_enable_reg[`BIT_POSITION_SELECT];

  logic robbed_fmt, multi_fmt;
  assign robbed_fmt = (frame_format == FMT_SF) || (frame_format == FMT_ESF) || (frame_format == FMT_SLC96);
  assign multi_fmt  = (frame_format == FMT_ESF) || (frame_format == FMT_SLC96);

  // ----------------------------------------
  // indirect access to payload tables
  // ----------------------------------------
  logic [7:0] channel_substitution_select_mem  [CH];
  logic [7:0] data_trunk_code_mem   [CH];
  logic [7:0] trunk_mem  [CH];
  logic [7:0] pl_ctrl, pl_data, pl_rd;
  logic       pl_busy, pl_we, pl_ok;
  logic [6:0] pl_a;

  assign pl_a  = pl_ctrl[6:0];
  assign pl_ok = in_range(pl_a, 7'h01, 7'(CH)) || in_range(pl_a, 7'h21, 7'(8'h20 + CH))
              || in_range(pl_a, 7'h41, 7'(8'h40 + CH));

  always_comb begin
    pl_rd = 8'h00;
    if (in_range(pl_a, 7'h01, 7'(CH))) pl_rd = channel_substitution_select_mem[5'(pl_a - 7'h01)];
    else if (in_range(pl_a, 7'h21, 7'(8'h20 + CH))) pl_rd = data_trunk_code_mem[5'(pl_a - 7'h21)];
    else if (in_range(pl_a, 7'h41, 7'(8'h40 + CH))) pl_rd = trunk_mem[5'(pl_a - 7'h41)];
  end

  indirect_access_engine #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_pl_access (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .ctrl_write (wr && (addr == `OFS_RX_PAYLOAD_ACCESS_CONTROL)),
    .data_write (wr && (addr == `OFS_RX_PAYLOAD_ACCESS_DATA)),
    .wdata      (wdata),
    .addr_ok    (pl_ok),
    .rd_data_in (pl_rd),
    .ctrl_reg   (pl_ctrl),
    .data_reg   (pl_data),
    .busy       (pl_busy),
    .mem_we     (pl_we)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CH; i++) begin
        channel_substitution_select_mem[i] <= `RST_ZERO_BYTE;
        data_trunk_code_mem[i]  <= `RST_ZERO_BYTE;
        trunk_mem[i] <= `RST_ZERO_BYTE;
      end
    end else if (pl_we) begin
      if (in_range(pl_a, 7'h01, 7'(CH))) channel_substitution_select_mem[5'(pl_a - 7'h01)] <= pl_data;
      else if (in_range(pl_a, 7'h21, 7'(8'h20 + CH))) data_trunk_code_mem[5'(pl_a - 7'h21)] <= pl_data;
      else trunk_mem[5'(pl_a - 7'h41)] <= pl_data;
    end
  end

  // ----------------------------------------
  // signaling buffer
  // ----------------------------------------
  logic [3:0] stored   [CH];
  logic [3:0] snap_reg [CH];
  logic [3:0] word_in;
  logic [7:0] sb_ctrl, sb_data, sb_rd;
  logic       sb_busy, sb_ok;

  // four-state keeps A and B only
  assign word_in = (multi_fmt && !width_sel) ? {sig_word_abcd[3:2], 2'b00} : sig_word_abcd;

  for (genvar g = 0; g < CH; g++) begin : g_chan
    signaling_channel u_chan (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .word_valid (sig_word_valid && (sig_word_chan == 5'(g))),
      .word       (word_in),
      .freeze     (freeze),
      .debounce   (debounce),
      .stored_reg (stored[g]),
      .change     (change_set[g])
    );
  end
  for (genvar g = CH; g < 24; g++) begin : g_pad
    assign change_set[g] = 1'b0;
  end

  assign sb_ok = in_range(sb_ctrl[6:0], 7'h01, 7'(CH));
  assign sb_rd = sb_ok ? {4'h0, stored[5'(sb_ctrl[6:0] - 7'h01)]} : 8'h00;

  // extracted signaling is hardware-owned; indirect writes only move busy
  indirect_access_engine #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_sb_access (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .ctrl_write (wr && (addr == `OFS_RX_SIGNALING_ACCESS_CONTROL)),
    .data_write (wr && (addr == `OFS_RX_SIGNALING_ACCESS_DATA)),
    .wdata      (wdata),
    .addr_ok    (sb_ok),
    .rd_data_in (sb_rd),
    .ctrl_reg   (sb_ctrl),
    .data_reg   (sb_data),
    .busy       (sb_busy),
    .mem_we     ()
  );

  // latch at superframe start so every frame of it sees one value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CH; i++) snap_reg[i] <= 4'h0;
    end else if (superframe_start) begin
      for (int i = 0; i < CH; i++) snap_reg[i] <= stored[i];
    end
  end

  // ----------------------------------------
  // change flags and interrupt
  // ----------------------------------------
  assign change_clear = {(wr && addr == `OFS_SIGNALING_CHANGE_2) ? wdata : 8'h00,
                         (wr && addr == `OFS_SIGNALING_CHANGE_1) ? wdata : 8'h00,
                         (wr && addr == `OFS_SIGNALING_CHANGE_0) ? wdata : 8'h00};

  // a change in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      change_flag_reg <= 24'h000000;
    end else begin
      change_flag_reg <= (change_flag_reg & ~change_clear) | change_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_en && (|change_flag_reg);
    end
  end
  assign signaling_irq = irq_reg;

  // ----------------------------------------
  // receive payload and signaling output
  // ----------------------------------------
  logic [7:0] alaw_mw  [8];
  logic [7:0] mulaw_mw [8];
  logic [2:0] mw_phase_reg;
  logic [4:0] pc;
  logic [2:0] sub_sel;
  logic [7:0] pay_next;
  logic [3:0] sig_src, sig_next;
  logic       trk_on;

  assign alaw_mw  = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hb4, 8'ha1, 8'ha1, 8'hb4};
  assign mulaw_mw = '{8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};
  assign pc       = (payload_chan < 5'(CH)) ? payload_chan : 5'h0;

  // milliwatt sequence steps once per frame, after the last channel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mw_phase_reg <= 3'h0;
    end else if (payload_valid && payload_chan == 5'(CH - 1)) begin
      mw_phase_reg <= mw_phase_reg + 3'h1;
    end
  end

  always_comb begin
    sub_sel = (global_substitution_select == SUB_PER_CHANNEL) ? channel_substitution_select_mem[pc][7:5] : global_substitution_select;
    case (sub_sel)
      SUB_DATA_TRUNK: pay_next = data_trunk_code_mem[pc];
      SUB_ALAW_MW:    pay_next = alaw_mw[mw_phase_reg];
      SUB_MULAW_MW:   pay_next = mulaw_mw[mw_phase_reg];
      default:        pay_next = payload_in;
    endcase
    if (!rx_enable) pay_next = payload_in;
  end

  always_comb begin
    trk_on  = gtrk_en || trunk_mem[pc][`BIT_CHANNEL_TRUNK];
    sig_src = (snap_en && in_sync && robbed_fmt) ? snap_reg[pc] : stored[pc];
    if (!rx_enable) begin
      sig_next = stored[pc];
    end else begin
      if (robbed_fmt && fix_en) sig_next = {4{fix_level}};
      else if (trk_on) sig_next = trunk_mem[pc][3:0];
      else sig_next = sig_src;
      if (multi_fmt && pos_sel) sig_next = {sig_next[3:2], 2'b00};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      payload_out_valid    <= 1'b0;
      payload_out          <= 8'h00;
      rx_signaling_out_pin <= 4'h0;
    end else begin
      payload_out_valid <= payload_valid;
      if (payload_valid) begin
        payload_out          <= pay_next;
        rx_signaling_out_pin <= sig_next;
      end
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_TX_PAYLOAD_CTRL_ENABLE:      rdata_reg <= tx_ctrl_enable_reg;
        `OFS_RX_PAYLOAD_ACCESS_STATUS:    rdata_reg <= {7'h00, pl_busy};
        `OFS_RX_PAYLOAD_ACCESS_CONTROL:   rdata_reg <= pl_ctrl;
        `OFS_RX_PAYLOAD_ACCESS_DATA:      rdata_reg <= pl_data;
        `OFS_RX_PAYLOAD_CONFIG:           rdata_reg <= rx_config_reg;
        `OFS_RX_PAYLOAD_CTRL_ENABLE:      rdata_reg <= rx_ctrl_enable_reg;
        `OFS_RX_SIGNALING_BUFFER_CONFIG:  rdata_reg <= sigbuf_config_reg;
        `OFS_RX_SIGNALING_ACCESS_STATUS:  rdata_reg <= {7'h00, sb_busy};
        `OFS_RX_SIGNALING_ACCESS_CONTROL: rdata_reg <= sb_ctrl;
        `OFS_RX_SIGNALING_ACCESS_DATA:    rdata_reg <= sb_data;
        `OFS_SIGNALING_CHANGE_0:          rdata_reg <= change_flag_reg[7:0];
        `OFS_SIGNALING_CHANGE_1:          rdata_reg <= change_flag_reg[15:8];
        `OFS_SIGNALING_CHANGE_2:          rdata_reg <= change_flag_reg[23:16];
        default:                          rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

endmodule

//--- rtl/rx_payload_signaling_defines.svh
`ifndef RX_PAYLOAD_SIGNALING_DEFINES_SVH
`define RX_PAYLOAD_SIGNALING_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_TX_PAYLOAD_CTRL_ENABLE      8'hcc
`define OFS_RX_PAYLOAD_ACCESS_STATUS    8'hcd
`define OFS_RX_PAYLOAD_ACCESS_CONTROL   8'hce
`define OFS_RX_PAYLOAD_ACCESS_DATA      8'hcf
`define OFS_RX_PAYLOAD_CONFIG           8'hd0
`define OFS_RX_PAYLOAD_CTRL_ENABLE      8'hd1
`define OFS_RX_SIGNALING_BUFFER_CONFIG  8'hd2
`define OFS_RX_SIGNALING_ACCESS_STATUS  8'hd3
`define OFS_RX_SIGNALING_ACCESS_CONTROL 8'hd4
`define OFS_RX_SIGNALING_ACCESS_DATA    8'hd5
`define OFS_SIGNALING_CHANGE_0          8'hd6
`define OFS_SIGNALING_CHANGE_1          8'hd7
`define OFS_SIGNALING_CHANGE_2          8'hd8

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_POSITION_SELECT   3
`define BIT_FIX_ENABLE        2
`define BIT_FIX_LEVEL         1
`define BIT_FUNCTIONS_ENABLE  0
`define BIT_SNAPSHOT_ENABLE   7
`define BIT_GLOBAL_TRUNK      6
`define BIT_FREEZE            3
`define BIT_DEBOUNCE          2
`define BIT_IRQ_ENABLE        1
`define BIT_WIDTH_SELECT      0
`define BIT_DIRECTION         7
`define BIT_CHANNEL_TRUNK     4

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_RX_PAYLOAD_CONFIG  8'h80
`define RST_SIGNALING_CONFIG   8'h01
`define RST_ZERO_BYTE          8'h00
`define ACCESS_CYCLES          2

`endif

//--- rtl/sig_regs_pkg.sv
package sig_regs_pkg;

  typedef enum logic [1:0] {
    FMT_SF    = 2'h0,
    FMT_ESF   = 2'h1,
    FMT_SLC96 = 2'h2,
    FMT_OTHER = 2'h3
  } frame_format_t;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'h1,
    ACC_BUSY = 2'h2
  } access_state_t;

  typedef enum logic [2:0] {
    SUB_PER_CHANNEL = 3'h0,
    SUB_DATA_TRUNK  = 3'h1,
    SUB_ALAW_MW     = 3'h2,
    SUB_MULAW_MW    = 3'h3
  } substitution_t;

  function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

//--- rtl/indirect_access_engine.sv
`timescale 1ns/10ps
`include "rx_payload_signaling_defines.svh"

module indirect_access_engine
  import sig_regs_pkg::*;
#(
  parameter int ACCESS_CYCLES = `ACCESS_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ctrl_write,
  input  wire logic       data_write,
  input  wire logic [7:0] wdata,
  input  wire logic       addr_ok,
  input  wire logic [7:0] rd_data_in,
  output logic      [7:0] ctrl_reg,
  output logic      [7:0] data_reg,
  output logic            busy,
  output logic            mem_we
);

  access_state_t state_reg;
  logic [3:0]    cnt_reg;
  logic          done;

  // the 4-bit countdown cannot serve longer transfers
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 15) begin : g_bad_cycles
    $error("ACCESS_CYCLES out of range");
  end

  assign busy   = (state_reg == ACC_BUSY);
  assign done   = busy && (cnt_reg == 4'h0);
  assign mem_we = done && !ctrl_reg[`BIT_DIRECTION] && addr_ok;

  // ----------------------------------------
  // control and sequencing
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ACC_IDLE;
      ctrl_reg  <= `RST_ZERO_BYTE;
      cnt_reg   <= 4'h0;
    end else begin
      case (state_reg)
        ACC_IDLE: begin
          if (ctrl_write) begin
            ctrl_reg  <= wdata;
            cnt_reg   <= 4'(ACCESS_CYCLES - 1);
            state_reg <= ACC_BUSY;
          end
        end
        ACC_BUSY: begin
          // control writes while busy are dropped
          if (cnt_reg == 4'h0) begin
            state_reg <= ACC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= ACC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // data holding register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= `RST_ZERO_BYTE;
    end else if (done && ctrl_reg[`BIT_DIRECTION]) begin
      data_reg <= addr_ok ? rd_data_in : 8'h00;
    end else if (data_write && !busy) begin
      data_reg <= wdata;
    end
  end

endmodule

//--- rtl/signaling_channel.sv
`timescale 1ns/10ps

module signaling_channel (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       word_valid,
  input  wire logic [3:0] word,
  input  wire logic       freeze,
  input  wire logic       debounce,
  output logic      [3:0] stored_reg,
  output logic            change
);

  logic [3:0] last_reg;
  logic       agree;
  logic       take;

  // one-word history so a glitch on a single superframe is not stored
  assign agree  = (word == last_reg);
  assign take   = word_valid && !freeze && (!debounce || agree);
  assign change = take && (word != stored_reg);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= 4'h0;
    end else if (word_valid) begin
      last_reg <= word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stored_reg <= 4'h0;
    end else if (take) begin
      stored_reg <= word;
    end
  end

endmodule

//--- test/rx_payload_signaling_regs_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// bus side checks and payload valid delay
// ----------------------------------------
module rx_payload_signaling_regs_assertions #(
  parameter int NUM_CHANNELS  = 24,
  parameter int ACCESS_CYCLES = 2
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       payload_valid,
  input wire logic       payload_out_valid,
  input wire logic       tx_payload_functions_enable,
  input wire logic       tx_signaling_position_select
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_tx_enable:
    assert property (wr && addr == 8'hcc |=> tx_payload_functions_enable == $past(wdata[0]))
      else $error("tx enable does not follow write");
  a_tx_hold:
    assert property (!(wr && addr == 8'hcc) |=> $stable(tx_payload_functions_enable))
      else $error("tx enable changed without write");
  a_tx_position:
    assert property (wr && addr == 8'hcc |=> tx_signaling_position_select == $past(wdata[3]))
      else $error("position select does not follow write");
  a_busy_set:
    assert property ((wr && addr == 8'hce) ##1 (rd && addr == 8'hcd) |=> rdata == 8'h01)
      else $error("busy not shown after control write");
  a_busy_clear:
    assert property ((wr && addr == 8'hce) ##1 (!(wr && addr == 8'hce))[*4] ##1 (rd && addr == 8'hcd)
      |=> rdata == 8'h00) else $error("busy did not clear");
  a_status_bits:
    assert property (rd && (addr == 8'hcd || addr == 8'hd3) |=> rdata[7:1] == 7'h00)
      else $error("status upper bits not zero");
  a_data_back:
    assert property ((wr && addr == 8'hcf) ##1 (rd && addr == 8'hcf) |=> rdata == $past(wdata, 2))
      else $error("data register readback wrong");
  a_valid_follow:
    assert property (payload_out_valid == $past(payload_valid))
      else $error("payload valid not delayed by one");
endmodule

bind rx_payload_signaling_regs rx_payload_signaling_regs_assertions #(
  .NUM_CHANNELS(NUM_CHANNELS), .ACCESS_CYCLES(ACCESS_CYCLES)
) rx_payload_signaling_regs_assertions_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .payload_valid(payload_valid), .payload_out_valid(payload_out_valid),
  .tx_payload_functions_enable(tx_payload_functions_enable),
  .tx_signaling_position_select(tx_signaling_position_select)
);

//--- test/tb.sv
`timescale 1ns/10ps
// ----------------------------------------
// bench
// ----------------------------------------
module tb;
  import sig_regs_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rst_n   = 1'b0;
  logic [7:0]    addr    = 8'h00;
  logic [7:0]    wdata   = 8'h00;
  logic          wr      = 1'b0;
  logic          rd      = 1'b0;
  logic [7:0]    rdata;
  frame_format_t fmt     = FMT_SF;
  logic          sv      = 1'b0;
  logic [4:0]    sch     = 5'h00;
  logic [3:0]    sab     = 4'h0;
  logic          pv      = 1'b0;
  logic [4:0]    pch     = 5'h00;
  logic [7:0]    pin     = 8'h00;
  logic          sync    = 1'b0;
  logic          sfs     = 1'b0;
  logic [7:0]    pout;
  logic [3:0]    spin;
  logic          pov;
  logic          txe;
  logic          txp;
  logic          irq;
  int            bad_count = 0;
  int            tests_run = 0;

  always #4 clk_sys = ~clk_sys;

  rx_payload_signaling_regs #(.NUM_CHANNELS(24), .ACCESS_CYCLES(2)) rx_payload_signaling_regs_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .frame_format(fmt), .in_sync(sync), .superframe_start(sfs), .sig_word_valid(sv),
    .sig_word_chan(sch), .sig_word_abcd(sab), .payload_valid(pv), .payload_chan(pch),
    .payload_in(pin), .payload_out_valid(pov), .payload_out(pout), .rx_signaling_out_pin(spin),
    .tx_payload_functions_enable(txe), .tx_signaling_position_select(txp), .signaling_irq(irq));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobes stay up so requests may follow with no gap
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
  endtask
  task automatic idle();
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    idle();
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    idle();
    chk(what, e, rdata);
  endtask
  // bounded wait on a busy flag
  task automatic poll(input logic [7:0] a);
    for (int i = 0; i < 20; i++) begin
      acc(1'b0, a, 8'h00);
      idle();
      if (rdata === 8'h00) return;
    end
    chk("busy wait", 8'h00, rdata);
    tally_and_finish();
  endtask
  task automatic iwr(input logic [7:0] c, input logic [7:0] t, input logic [7:0] d);
    wreg(c + 8'h01, d);
    wreg(c, t);
    poll(c - 8'h01);
  endtask
  task automatic ird(input logic [7:0] c, input logic [7:0] t, input logic [7:0] e);
    wreg(c, 8'h80 | t);
    poll(c - 8'h01);
    rchk("indirect read", c + 8'h01, e);
  endtask
  task automatic sig(input logic [4:0] ch, input logic [3:0] v);
    @(posedge clk_sys);
    sv <= 1'b1;
    sch <= ch;
    sab <= v;
    @(posedge clk_sys);
    sv <= 1'b0;
  endtask
  task automatic pay(input logic [4:0] ch, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk_sys);
    pv <= 1'b1;
    pch <= ch;
    pin <= d;
    @(posedge clk_sys);
    pv <= 1'b0;
    #1;
    chk("payload", e, pout);
  endtask

  task automatic t_reset();
    logic [7:0] ofs [11] = '{8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'h00};
    logic [7:0] dft [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++) rchk("reset value", ofs[i], dft[i]);
    $display("reset test done");
  endtask
  task automatic t_tx();
    wreg(8'hcc, 8'hff);
    chk("tx enable", 8'h01, {7'h00, txe});
    chk("tx position", 8'h01, {7'h00, txp});
    rchk("tx readback", 8'hcc, 8'h09);
    wreg(8'hcc, 8'h00);
    chk("tx off", 8'h00, {6'h00, txe, txp});
    $display("tx test done");
  endtask
  task automatic t_indirect();
    acc(1'b1, 8'hcf, 8'h5a);
    acc(1'b0, 8'hcf, 8'h00);
    idle();
    chk("data reg", 8'h5a, rdata);
    wreg(8'hce, 8'h21);
    repeat (3) @(posedge clk_sys);
    rchk("busy end", 8'hcd, 8'h00);
    ird(8'hce, 8'h21, 8'h5a);
    ird(8'hce, 8'h19, 8'h00);
    wreg(8'hcf, 8'h11);
    acc(1'b1, 8'hce, 8'h22);
    acc(1'b1, 8'hce, 8'h23);
    acc(1'b0, 8'hcd, 8'h00);
    idle();
    chk("busy", 8'h01, rdata);
    poll(8'hcd);
    ird(8'hce, 8'h22, 8'h11);
    ird(8'hce, 8'h23, 8'h00);
    $display("indirect test done");
  endtask
  task automatic t_payload();
    pay(5'd0, 8'h33, 8'h33);
    wreg(8'hd1, 8'h01);
    wreg(8'hd0, 8'h81);
    pay(5'd0, 8'h33, 8'h5a);
    wreg(8'hd0, 8'h85);
    pay(5'd0, 8'h33, 8'h33);
    wreg(8'hd0, 8'h82);
    pay(5'd0, 8'h33, 8'h34);
    wreg(8'hd0, 8'h83);
    pay(5'd0, 8'h33, 8'h1e);
    iwr(8'hce, 8'h01, 8'h20);
    wreg(8'hd0, 8'h80);
    pay(5'd0, 8'h33, 8'h5a);
    $display("payload test done");
  endtask
  task automatic t_signaling();
    wreg(8'hd2, 8'h03);
    sig(5'd0, 4'h9);
    rchk("change flag", 8'hd6, 8'h01);
    chk("irq on", 8'h01, {7'h00, irq});
    ird(8'hd4, 8'h01, 8'h09);
    wreg(8'hd6, 8'h01);
    rchk("flag clear", 8'hd6, 8'h00);
    chk("irq off", 8'h00, {7'h00, irq});
    wreg(8'hd2, 8'h01);
    sig(5'd0, 4'h6);
    rchk("masked flag", 8'hd6, 8'h01);
    chk("irq masked", 8'h00, {7'h00, irq});
    ird(8'hd4, 8'h19, 8'h00);
    fmt <= FMT_ESF;
    wreg(8'hd2, 8'h00);
    sig(5'd1, 4'hf);
    ird(8'hd4, 8'h02, 8'h0c);
    wreg(8'hd2, 8'h09);
    sig(5'd1, 4'h3);
    ird(8'hd4, 8'h02, 8'h0c);
    wreg(8'hd2, 8'h05);
    sig(5'd1, 4'h5);
    ird(8'hd4, 8'h02, 8'h0c);
    sig(5'd1, 4'h5);
    ird(8'hd4, 8'h02, 8'h05);
    $display("signaling test done");
  endtask
  // fix outranks stored, trunk outranks stored; fix and trunk are never driven together
  task automatic t_pin();
    wreg(8'hd0, 8'h00);
    wreg(8'hd1, 8'h09);
    pay(5'd1, 8'h00, 8'h00);
    chk("position", 8'h04, {4'h0, spin});
    wreg(8'hd1, 8'h07);
    pay(5'd1, 8'h00, 8'h00);
    chk("fix high", 8'h0f, {4'h0, spin});
    wreg(8'hd1, 8'h05);
    pay(5'd1, 8'h00, 8'h00);
    chk("fix low", 8'h00, {4'h0, spin});
    iwr(8'hce, 8'h42, 8'h0a);
    wreg(8'hd1, 8'h01);
    wreg(8'hd0, 8'h40);
    pay(5'd1, 8'h00, 8'h00);
    chk("global trunk", 8'h0a, {4'h0, spin});
    wreg(8'hd0, 8'h00);
    pay(5'd1, 8'h00, 8'h00);
    chk("stored", 8'h05, {4'h0, spin});
    wreg(8'hd0, 8'h80);
    @(posedge clk_sys);
    sync <= 1'b1;
    sfs <= 1'b1;
    @(posedge clk_sys);
    sfs <= 1'b0;
    sig(5'd1, 4'h6);
    sig(5'd1, 4'h6);
    pay(5'd1, 8'h00, 8'h00);
    chk("snapshot", 8'h05, {4'h0, spin});
    sync <= 1'b0;
    pay(5'd1, 8'h00, 8'h00);
    chk("no snapshot", 8'h06, {4'h0, spin});
    iwr(8'hce, 8'h42, 8'h1a);
    pay(5'd1, 8'h00, 8'h00);
    chk("channel trunk", 8'h0a, {4'h0, spin});
    $display("pin test done");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_tx();
    t_indirect();
    t_payload();
    t_signaling();
    t_pin();
    tally_and_finish();
  end
endmodule
